// *** design/lcs_pkg.sv ***
package lcs_pkg;
    localparam int CLK_HZ          = 50_000_000;
    localparam int MS_PER_S        = 1000;
    localparam int BL_TIMEOUT_S    = 15 * 60;
    localparam int AUD_TIMEOUT_S   = 15 * 60;
    localparam int CHANNEL_SELECT_BUTTON_HOLD_S     = 3;
    localparam int RESTORE_HOLD_S  = 5;
    localparam int TUNE_MS         = 2000;
    localparam int FULL_SENS_MS    = 30000;
    localparam int FLASH_PER_S     = 3;
    localparam int FLASH_HALF_MS   = MS_PER_S / (2 * FLASH_PER_S);
    localparam int THR_DEN         = 40000;
    localparam int THR_L1          = 256;
    localparam int IND_MIN_UH      = 20;
    localparam int IND_MAX_UH      = 2500;
    localparam int IND_UNITS_PER_UH = 100;
    localparam int IND_W           = 24;
    localparam int CFG_W           = 19;
    localparam logic [26:0] FAULT_DEN = 27'h4;
    localparam logic [26:0] FAULT_LO  = 27'h3;
    localparam logic [26:0] FAULT_HI  = 27'h5;

    localparam logic [3:0] SENS_MIN  = 4'h1;
    localparam logic [3:0] SENS_MAX  = 4'h9;
    localparam logic [3:0] SENS_DEF  = 4'h6;
    localparam logic [2:0] FREQ_DEF0 = 3'h3;
    localparam logic [2:0] FREQ_DEF1 = 3'h7;

    // Filter-off response times in ms: 20, 27, 42, 72, 133
    localparam logic [7:0] RESP_FAST_MS = 8'h14;
    localparam logic [7:0] RESP_L6_MS   = 8'h1b;
    localparam logic [7:0] RESP_L7_MS   = 8'h2a;
    localparam logic [7:0] RESP_L8_MS   = 8'h48;
    localparam logic [7:0] RESP_SLOW_MS = 8'h85;

    localparam logic [3:0] BTN_CHANNEL_SELECT_BUTTON_ONLY = 4'h1;

    localparam logic [4:0] A_CFG0 = 5'h00;
    localparam logic [4:0] A_CFG1 = 5'h04;
    localparam logic [4:0] A_GLOB = 5'h08;
    localparam logic [4:0] A_STAT = 5'h0c;
    localparam logic [4:0] A_FAIL = 5'h10;

    typedef struct packed {
        logic       opt11;
        logic       opt2;
        logic       opt1;
        logic [3:0] ext;
        logic [3:0] dly;
        logic       rsv;
        logic [2:0] freq;
        logic [3:0] sens;
    } lcs_cfg_t;

    localparam lcs_cfg_t CFG_DEF0 = '{sens: SENS_DEF, freq: FREQ_DEF0, default: '0};
    localparam lcs_cfg_t CFG_DEF1 = '{sens: SENS_DEF, freq: FREQ_DEF1, default: '0};

    typedef struct packed {
        lcs_cfg_t         cfg;
        logic [14:0]      tune_ms;
        logic [IND_W-1:0] ref_val;
        logic             occ;
        logic [7:0]       filt_ms;
        logic             fault;
        logic             flt_hi;
        logic             flash;
        logic [7:0]       fcnt;
        logic [3:0]       dly_s;
        logic [3:0]       ext_s;
        logic             call;
    } lcs_ch_t;

    typedef struct packed {
        logic ind;
        logic call;
        logic loop_fail;
        logic low_inductance_fault;
        logic high_inductance_fault;
        logic tuned;
        logic full;
        logic flash;
        logic occ;
    } lcs_chout_t;

    typedef struct packed {
        lcs_ch_t [1:0] ch;
        logic          nf_dis;
        logic          sel;
        logic [3:0]    btn_q;
        logic [15:0]   ms_cnt;
        logic [9:0]    ms_in_s;
        logic          bl;
        logic [9:0]    bl_s;
        logic [2:0]    hold_s;
        logic          hold_done;
        logic [9:0]    aud_s;
        logic [7:0]    flash_ms;
        logic          flash_ph;
        logic          dp_act;
        logic          dp_wr;
        logic [4:0]    dp_addr;
        logic [31:0]   rdata;
    } lcs_st_t;

    function automatic logic [7:0] lcs_resp_ms(input logic [3:0] sens, input logic nf_dis);
        logic [7:0] r;
        r = RESP_SLOW_MS;
        if (nf_dis) begin
            case (sens)
                4'h6:    r = RESP_L6_MS;
                4'h7:    r = RESP_L7_MS;
                4'h8:    r = RESP_L8_MS;
                4'h9:    r = RESP_SLOW_MS;
                default: r = RESP_FAST_MS;
            endcase
        end
        return r;
    endfunction : lcs_resp_ms

    // Threshold in units of 1/THR_DEN, halving per level
    function automatic logic [8:0] lcs_thr(input logic [3:0] sens);
        return 9'(THR_L1 >> (sens - SENS_MIN));
    endfunction : lcs_thr
endpackage : lcs_pkg

// *** design/lcs_top.sv ***
`timescale 1ns/1ns
module lcs_top
    import lcs_pkg::*;
#(
    parameter int unsigned      MS_CYCLES = CLK_HZ / MS_PER_S,
    parameter logic [IND_W-1:0] IND_MIN   = IND_W'(IND_MIN_UH * IND_UNITS_PER_UH),
    parameter logic [IND_W-1:0] IND_MAX   = IND_W'(IND_MAX_UH * IND_UNITS_PER_UH)
)(
    input  wire  logic                   hclk,
    input  wire  logic                   hresetn,
    input  wire  logic                   hsel,
    input  wire  logic [31:0]            haddr,
    input  wire  logic [1:0]             htrans,
    input  wire  logic                   hwrite,
    input  wire  logic [2:0]             hsize,
    input  wire  logic [31:0]            hwdata,
    input  wire  logic                   hready,
    output logic       [31:0]            hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire  logic [3:0]             front_btn,
    input  wire  logic [1:0]             phase_green,
    input  wire  logic [1:0][IND_W-1:0]  loop_ind,
    output lcs_chout_t [1:0]             channel_select_button_out,
    output logic                         backlight,
    output logic                         display_test,
    output logic                         restore_active,
    output logic       [2:0]             restore_count,
    output logic                         audible,
    output logic                         sel_channel
);
    // power-up: defaults, all diagnostic options off
    localparam lcs_st_t ST_RST = '{ch: '{'{cfg: CFG_DEF1, default: '0}, '{cfg: CFG_DEF0, default: '0}},
                                   default: '0};

    lcs_st_t s;
    lcs_st_t n;
    logic    all_on;
    logic    channel_select_button_only;

    assign all_on    = &s.btn_q;
    assign channel_select_button_only = s.btn_q == BTN_CHANNEL_SELECT_BUTTON_ONLY;

    always_comb begin
        logic             ms_tick;
        logic             sec_tick;
        logic             btn_chg;
        logic             wr;
        logic             restore;
        logic             channel_select_button_hold;
        logic [1:0]       rst_ch;
        lcs_cfg_t         wcfg;
        logic [IND_W-1:0] m;
        logic [IND_W-1:0] dif;
        logic [39:0]      lhs;
        logic [39:0]      rhs;
        logic [26:0]      m4;
        logic [9:0]       thr;
        logic             in_rng;
        logic             tuned;
        logic             full;
        logic             lo_c;
        logic             hi_c;
        logic             raw;
        logic             occ_n;
        logic             new_f;
        n         = s;
        ms_tick   = s.ms_cnt == 16'(MS_CYCLES - 1);
        sec_tick  = ms_tick && s.ms_in_s == 10'(MS_PER_S - 1);
        btn_chg   = front_btn != s.btn_q;
        wr        = s.dp_act && s.dp_wr;
        restore   = 1'b0;
        channel_select_button_hold = 1'b0;
        rst_ch    = '0;
        wcfg      = lcs_cfg_t'(hwdata[CFG_W-1:0]);
        wcfg.rsv  = 1'b0;
        m = '0;
        dif = '0;
        lhs = '0;
        rhs = '0;
        m4 = '0;
        thr = '0;
        in_rng = 1'b0;
        tuned = 1'b0;
        full = 1'b0;
        lo_c = 1'b0;
        hi_c = 1'b0;
        raw = 1'b0;
        occ_n = 1'b0;
        new_f = 1'b0;

        n.ms_cnt = ms_tick ? '0 : s.ms_cnt + 16'h1;
        if (ms_tick) begin
            n.ms_in_s = sec_tick ? '0 : s.ms_in_s + 10'h1;
        end
        n.btn_q = front_btn;
        // shared second tick restarts on any button change
        if (btn_chg) begin
            n.ms_in_s = '0;
        end

        // backlight on press, off after idle timeout
        if (|(front_btn & ~s.btn_q)) begin
            n.bl   = 1'b1;
            n.bl_s = '0;
        end else if (s.bl && sec_tick) begin
            if (s.bl_s == 10'(BL_TIMEOUT_S - 1)) begin
                n.bl = 1'b0;
            end else begin
                n.bl_s = s.bl_s + 10'h1;
            end
        end

        if (btn_chg) begin
            n.hold_s    = '0;
            n.hold_done = 1'b0;
        end else if (sec_tick && (channel_select_button_only || all_on) && !s.hold_done) begin
            n.hold_s = s.hold_s + 3'h1;
        end
        // channel button held selects a channel reset
        channel_select_button_hold = !btn_chg && channel_select_button_only && !s.hold_done && s.hold_s == 3'(CHANNEL_SELECT_BUTTON_HOLD_S);
        // all four held for the full countdown
        restore   = !btn_chg && all_on && !s.hold_done && s.hold_s == 3'(RESTORE_HOLD_S);
        if (channel_select_button_hold || restore) begin
            n.hold_done = 1'b1;
        end
        if (front_btn == BTN_CHANNEL_SELECT_BUTTON_ONLY && s.btn_q == '0) begin
            n.sel = !s.sel;
        end

        if (ms_tick) begin
            if (s.flash_ms == 8'(FLASH_HALF_MS - 1)) begin
                n.flash_ms = '0;
                n.flash_ph = !s.flash_ph;
            end else begin
                n.flash_ms = s.flash_ms + 8'h1;
            end
        end

        if ((s.ch[0].cfg.opt11 || s.ch[1].cfg.opt11) && sec_tick) begin
            if (s.aud_s == 10'(AUD_TIMEOUT_S - 1)) begin
                n.ch[0].cfg.opt11 = 1'b0;
                n.ch[1].cfg.opt11 = 1'b0;
            end else begin
                n.aud_s = s.aud_s + 10'h1;
            end
        end

        n.dp_act  = hsel && htrans[1] && hready;
        n.dp_wr   = hwrite;
        n.dp_addr = haddr[4:0];
        if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[4:0])
                A_CFG0:  n.rdata = 32'(s.ch[0].cfg);
                A_CFG1:  n.rdata = 32'(s.ch[1].cfg);
                A_GLOB:  n.rdata = 32'(s.nf_dis);
                A_STAT:  n.rdata = {restore_count, restore_active, display_test, s.bl, s.sel,
                                    channel_select_button_out[1], 7'h0, channel_select_button_out[0]};
                A_FAIL:  n.rdata = {16'h0, s.ch[1].fcnt, s.ch[0].fcnt};
                default: n.rdata = '0;
            endcase
        end

        for (int c = 0; c < 2; c++) begin
            if (wr && s.dp_addr == (c == 0 ? A_CFG0 : A_CFG1)) begin
                n.ch[c].cfg = wcfg;
                if (wcfg.sens != s.ch[c].cfg.sens || wcfg.freq != s.ch[c].cfg.freq) begin
                    rst_ch[c] = 1'b1;
                end
                // one channel at a time, timer restarts
                if (wcfg.opt11 && !s.ch[c].cfg.opt11) begin
                    n.ch[1 - c].cfg.opt11 = 1'b0;
                    n.aud_s = '0;
                end
            end
        end
        if (wr && s.dp_addr == A_GLOB) begin
            n.nf_dis = hwdata[0];
            if (hwdata[0] != s.nf_dis) begin
                rst_ch = 2'b11;
            end
        end
        if (channel_select_button_hold) begin
            rst_ch[s.sel] = 1'b1;
        end
        if (restore) begin
            n.ch[0].cfg = CFG_DEF0;
            n.ch[1].cfg = CFG_DEF1;
            n.nf_dis    = 1'b0;
            rst_ch      = 2'b11;
        end

        for (int c = 0; c < 2; c++) begin
            m      = loop_ind[c];
            in_rng = m >= IND_MIN && m <= IND_MAX;
            tuned  = s.ch[c].tune_ms >= 15'(TUNE_MS);
            full   = s.ch[c].tune_ms == 15'(FULL_SENS_MS);
            // tune at 2 s, full sensitivity at 30 s
            if (ms_tick && !full) begin
                if (s.ch[c].tune_ms != 15'(TUNE_MS - 1)) begin
                    n.ch[c].tune_ms = s.ch[c].tune_ms + 15'h1;
                end else if (in_rng) begin
                    // retune only with the loop back in range
                    n.ch[c].tune_ms = 15'(TUNE_MS);
                    n.ch[c].ref_val = m;
                end
            end

            m4   = 27'(m) * FAULT_DEN;
            lo_c = m < IND_MIN || (tuned && m4 < 27'(s.ch[c].ref_val) * FAULT_LO);
            hi_c = m > IND_MAX || (tuned && m4 > 27'(s.ch[c].ref_val) * FAULT_HI);
            new_f = (lo_c || hi_c) && !s.ch[c].fault;
            if (lo_c || hi_c) begin
                if (new_f) begin
                    n.ch[c].fcnt  = (&s.ch[c].fcnt) ? s.ch[c].fcnt : s.ch[c].fcnt + 8'h1;
                    n.ch[c].flash = 1'b1;
                end
                n.ch[c].fault  = 1'b1;
                n.ch[c].flt_hi = hi_c;
            end else begin
                n.ch[c].fault = 1'b0;
            end

            // threshold per level, coarser while warming up
            dif = s.ch[c].ref_val - m;
            thr = full ? 10'(lcs_thr(s.ch[c].cfg.sens)) : 10'(lcs_thr(s.ch[c].cfg.sens)) << 1;
            lhs = 40'(dif) * 40'(THR_DEN);
            rhs = 40'(s.ch[c].ref_val) * 40'(thr);
            raw = tuned && s.ch[c].cfg.sens >= SENS_MIN && s.ch[c].cfg.sens <= SENS_MAX
                  && m < s.ch[c].ref_val && lhs >= rhs;
            // change must persist for the response time
            if (raw == s.ch[c].occ) begin
                n.ch[c].filt_ms = '0;
            end else if (ms_tick) begin
                if (s.ch[c].filt_ms + 8'h1 >= lcs_resp_ms(s.ch[c].cfg.sens, s.nf_dis)) begin
                    n.ch[c].occ     = raw;
                    n.ch[c].filt_ms = '0;
                end else begin
                    n.ch[c].filt_ms = s.ch[c].filt_ms + 8'h1;
                end
            end

            occ_n = n.ch[c].occ;
            if (sec_tick && s.ch[c].dly_s != '0) begin
                n.ch[c].dly_s = s.ch[c].dly_s - 4'h1;
            end
            if (sec_tick && s.ch[c].ext_s != '0) begin
                n.ch[c].ext_s = s.ch[c].ext_s - 4'h1;
            end
            if (occ_n && !s.ch[c].occ) begin
                n.ch[c].dly_s = s.ch[c].cfg.dly;
                n.ch[c].ext_s = '0;
            end
            if (!occ_n) begin
                n.ch[c].dly_s = '0;
                if (s.ch[c].occ && s.ch[c].call) begin
                    n.ch[c].ext_s = s.ch[c].cfg.ext;
                end
            end
            if (phase_green[c]) begin
                n.ch[c].dly_s = '0;
            end
            n.ch[c].call = n.ch[c].fault || (occ_n && n.ch[c].dly_s == '0) || n.ch[c].ext_s != '0;

            // channel reset keeps options, clears count, holds fault
            // A failure landing on the reset cycle still counts and flashes: set wins
            if (rst_ch[c]) begin
                n.ch[c] = '{cfg: n.ch[c].cfg, fault: n.ch[c].fault, flt_hi: n.ch[c].flt_hi,
                            call: n.ch[c].fault, flash: new_f, fcnt: 8'(new_f), default: '0};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_out
        assign channel_select_button_out[c] = '{ind: s.ch[c].flash ? s.flash_ph
                                    : (s.ch[c].call || s.ch[c].dly_s != '0 || s.ch[c].ext_s != '0),
                               call: s.ch[c].call,
                               loop_fail: s.ch[c].fault,
                               low_inductance_fault: s.ch[c].fault && !s.ch[c].flt_hi,
                               high_inductance_fault: s.ch[c].fault && s.ch[c].flt_hi,
                               tuned: s.ch[c].tune_ms >= 15'(TUNE_MS),
                               full: s.ch[c].tune_ms == 15'(FULL_SENS_MS),
                               flash: s.ch[c].flash,
                               occ: s.ch[c].occ};
    end

    // display test on two or three buttons
    assign display_test   = $countones(s.btn_q) == 2 || $countones(s.btn_q) == 3;
    assign restore_active = all_on && !s.hold_done;
    assign restore_count  = restore_active ? 3'(RESTORE_HOLD_S) - s.hold_s : '0;
    assign audible        = (s.ch[0].cfg.opt11 && s.ch[0].occ) || (s.ch[1].cfg.opt11 && s.ch[1].occ);
    assign backlight      = s.bl;
    assign sel_channel    = s.sel;
    assign hrdata         = s.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_sel_held;
        channel_select_button_only && !s.hold_done && s.hold_s == 3'(CHANNEL_SELECT_BUTTON_HOLD_S) && front_btn == s.btn_q;
    endsequence
    sequence s_all_held;
        all_on && !s.hold_done && s.hold_s == 3'(RESTORE_HOLD_S) && front_btn == s.btn_q;
    endsequence

    a_bl_press: assert property (|(front_btn & ~s.btn_q) |=> backlight)
        else $error("backlight not lit by press");
    a_bl_timeout: assert property ($fell(backlight) |-> $past(s.bl_s) == 10'(BL_TIMEOUT_S - 1))
        else $error("backlight went off early");
    a_fail_call: assert property (s.ch[0].fault |-> channel_select_button_out[0].call)
        else $error("faulted channel without call");
    a_low_kind: assert property (loop_ind[0] < IND_MIN |=> channel_select_button_out[0].low_inductance_fault)
        else $error("short loop not reported low");
    a_flash_set: assert property ($rose(s.ch[0].fault) |-> s.ch[0].flash)
        else $error("failure did not latch flashing");
    a_flash_keep: assert property (s.ch[0].flash |=> s.ch[0].flash || s.ch[0].tune_ms == '0)
        else $error("flashing dropped without reset");
    a_fcnt_step: assert property ($rose(s.ch[0].fault) && $past(s.ch[0].fcnt) != 8'hff
        |-> s.ch[0].fcnt == (s.ch[0].tune_ms == '0 ? 8'h1 : $past(s.ch[0].fcnt) + 8'h1))
        else $error("failure counter did not step");
    a_green_abort: assert property (phase_green[0] |=> s.ch[0].dly_s == '0)
        else $error("delay timing survived green");
    a_nf_reset: assert property (s.dp_act && s.dp_wr && s.dp_addr == A_GLOB && hwdata[0] != s.nf_dis
        |=> s.ch[0].tune_ms == '0 && s.ch[1].tune_ms == '0)
        else $error("filter change did not reset both");
    a_opt_keep: assert property (s.dp_act && s.dp_wr && s.dp_addr == A_GLOB && !all_on
        |=> s.ch[0].cfg.opt1 == $past(s.ch[0].cfg.opt1) && s.ch[0].cfg.opt2 == $past(s.ch[0].cfg.opt2))
        else $error("diagnostic option lost on reset");
    a_tune_ref: assert property ($rose(channel_select_button_out[0].tuned) |-> s.ch[0].ref_val == $past(loop_ind[0]))
        else $error("reference not taken at tuning");
    a_sel_reset: assert property (s_sel_held
        |=> s.ch[$past(s.sel)].tune_ms == '0 && s.ch[$past(s.sel)].fcnt == '0)
        else $error("held channel button did not reset");
    a_restore: assert property (s_all_held |=> s.ch[0].cfg == CFG_DEF0 && s.ch[1].cfg == CFG_DEF1
        && !s.nf_dis)
        else $error("defaults not restored");
endmodule : lcs_top

// *** bench/lcs_field.sv ***
`timescale 1ns/1ns
module lcs_field
    import lcs_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic [1:0]            want_green,
    input  wire logic [1:0][IND_W-1:0] want_ind,
    output logic      [1:0]            phase_green = 2'h0,
    output logic      [1:0][IND_W-1:0] loop_ind = '0
);
    always @(posedge hclk) begin
        phase_green <= want_green;
    end
    // Loop holds its inductance between changes, as a real loop would
    always @(posedge hclk) begin
        loop_ind <= want_ind;
    end
endmodule : lcs_field

// *** bench/test_loop_channel_supervisor.sv ***
`timescale 1ns/1ns
module test_loop_channel_supervisor;
    import lcs_pkg::*;
    localparam int MSC = 2;
    logic                  hclk = 1'b0;
    logic                  hresetn = 1'b0;
    logic                  hsel = 1'b0;
    logic [31:0]           haddr = '0;
    logic [1:0]            htrans = 2'h0;
    logic                  hwrite = 1'b0;
    logic [31:0]           hwdata = '0;
    logic [3:0]            front_btn = 4'h0;
    logic [1:0]            want_green = 2'h0;
    logic [1:0][IND_W-1:0] want_ind = {2{24'h0186a0}};
    logic [1:0][IND_W-1:0] loop_ind;
    logic [1:0]            phase_green;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic [2:0]            restore_count;
    logic                  backlight, display_test, restore_active, sel_channel, hresp, audible;
    lcs_chout_t [1:0]      co;
    int                    num_errors = 0;
    int                    total_checks = 0;

    always #10 hclk = ~hclk;

    lcs_field field (.hclk(hclk), .want_green(want_green), .want_ind(want_ind),
        .phase_green(phase_green), .loop_ind(loop_ind));
    lcs_top #(.MS_CYCLES(MSC)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .front_btn(front_btn),
        .phase_green(phase_green), .loop_ind(loop_ind), .channel_select_button_out(co), .backlight(backlight),
        .display_test(display_test), .restore_active(restore_active),
        .restore_count(restore_count), .audible(audible), .sel_channel(sel_channel));

    task automatic summarize();
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        #1;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, {27'h0, a}, d, q);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp, msg);
    endtask : rd

    task automatic wait_ms(input int n);
        repeat (n * MSC) @(posedge hclk);
        #1;
    endtask : wait_ms

    task automatic btn(input logic [3:0] v, input int ms);
        @(posedge hclk);
        front_btn <= v;
        wait_ms(ms);
    endtask : btn

    task automatic t_reset();
        rd({27'h0, A_CFG0}, 32'h00000036, "cfg0 default");
        rd({27'h0, A_CFG1}, 32'h00000076, "cfg1 default");
        rd({27'h0, A_GLOB}, 32'h00000000, "filter default");
        rd(32'h00000014, 32'h00000000, "unmapped read");
        chk(hresp, 1'b0, "bus response not okay");
        wait_ms(1900);
        chk(co[0].tuned, 1'b0, "tuned too early");
        wait_ms(200);
        chk({co[1].tuned, co[0].tuned}, 2'h3, "not tuned in 2 s");
    endtask : t_reset

    task automatic t_panel();
        btn(4'h6, 2);
        chk({backlight, display_test}, 2'h3, "two buttons");
        btn(4'he, 2);
        chk(display_test, 1'b1, "three buttons");
        btn(4'h2, 2);
        chk(display_test, 1'b0, "one button");
        btn(4'h0, 2);
    endtask : t_panel

    // First pass: shorted loop and +30%; second pass: open loop and -30%
    task automatic t_fail();
        for (int k = 0; k < 2; k++) begin
            @(posedge hclk);
            want_ind <= (k == 0) ? {24'h01fbd0, 24'h0003e8} : {24'h0f4240, 24'h011170};
            repeat (4) @(posedge hclk);
            #1;
            chk({co[0].call, co[0].loop_fail, co[0].low_inductance_fault}, 3'h7, "ch0 low");
            chk({co[1].loop_fail, co[1].high_inductance_fault}, 2'h3, "ch1 high");
            @(posedge hclk);
            want_ind <= {2{24'h0186a0}};
            repeat (4) @(posedge hclk);
            #1;
            chk({co[1].loop_fail, co[0].loop_fail}, 2'h0, "fail message stays");
            chk({co[1].flash, co[0].flash}, 2'h3, "flash not latched");
        end
        rd({27'h0, A_FAIL}, 32'h00000202, "fail counts");
    endtask : t_fail

    task automatic t_channel_select_button();
        btn(4'h1, 3500);
        chk(sel_channel, 1'b1, "channel select");
        chk({co[1].flash, co[0].flash}, 2'h1, "hold resets selected only");
        btn(4'h0, 1700);
        chk(co[1].tuned, 1'b1, "retune after reset");
        rd({27'h0, A_FAIL}, 32'h00000002, "count after reset");
    endtask : t_channel_select_button

    // Channel 1: 3 s delay, audible option, 1% decrease
    task automatic t_detect();
        wr(A_CFG1, 32'h00040376);
        @(posedge hclk);
        want_ind[1] <= 24'h0182b8;
        wait_ms(100);
        chk(co[1].occ, 1'b0, "detect too fast");
        wait_ms(100);
        chk({co[1].occ, co[1].call, co[1].ind, audible}, 4'hb, "delay timing");
        @(posedge hclk);
        want_green <= 2'h2;
        wait_ms(2);
        chk({co[1].call, co[1].ind}, 2'h3, "green aborts delay");
        @(posedge hclk);
        want_green <= 2'h0;
        want_ind[1] <= 24'h0186a0;
        wait_ms(200);
        chk({co[1].occ, co[1].call, audible}, 3'h0, "call after leave");
    endtask : t_detect

    task automatic t_cfg();
        wr(A_CFG0, 32'h00010036);
        chk(co[0].flash, 1'b1, "option write reset");
        wr(A_CFG0, 32'h00010035);
        chk({co[1].tuned, co[0].tuned, co[0].flash}, 3'h4, "sens change reset");
        rd({27'h0, A_FAIL}, 32'h00000000, "count after sens reset");
        wr(A_GLOB, 32'h00000001);
        chk({co[1].tuned, co[0].tuned}, 2'h0, "filter change reset");
        rd({27'h0, A_CFG0}, 32'h00010035, "options kept");
    endtask : t_cfg

    task automatic t_restore();
        btn(4'hf, 2500);
        chk({restore_active, restore_count}, 4'hb, "countdown");
        btn(4'h0, 10);
        chk(restore_active, 1'b0, "abort");
        rd({27'h0, A_CFG0}, 32'h00010035, "aborted restore");
        btn(4'hf, 5500);
        btn(4'h0, 10);
        rd({27'h0, A_CFG0}, 32'h00000036, "restored cfg");
        rd({27'h0, A_GLOB}, 32'h00000000, "restored filter");
    endtask : t_restore

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_panel();
        t_fail();
        t_channel_select_button();
        t_detect();
        t_cfg();
        t_restore();
        summarize();
    end

    // Whole run is about 16 s of scaled time, some 32000 cycles
    initial begin
        repeat (60000) @(posedge hclk);
        num_errors++;
        summarize();
    end
endmodule : test_loop_channel_supervisor
